// File: logic/rtc_i2c_controller.sv
/*
 * Controller end: drives SCL by a divider, frames one byte command at a time, offers bus recovery.
 * Assumes the user issues one command while ready is high; the link joins this to the target.
 */
`timescale 1ns/1ps
module rtc_i2c_controller
#(
    parameter int unsigned HALF_CYCLES = rtc_link_pkg::SCL_HALF_CYCLES
)
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    rtc_link_if.controller   link,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_op,
    input  wire logic [7:0]  cmd_data,
    input  wire logic        cmd_ack,
    output logic             cmd_ready,
    output logic [7:0]       rsp_data,
    output logic             rsp_ack,
    output logic             rsp_valid
);
    // Ops: 0 start, 1 stop, 2 write byte, 3 read byte (cmd_ack = acknowledge), 4 recovery
    typedef enum logic [4:0]
    {
        C_IDLE = 5'h01,
        C_COND = 5'h02,
        C_BITS = 5'h04,
        C_RECV = 5'h08,
        C_DONE = 5'h10
    } cstate_t;

    typedef struct packed
    {
        logic [1:0] sda_sync;
        cstate_t    state;
        logic [2:0] op;
        logic [8:0] shift;
        logic [3:0] bit_cnt;
        logic [1:0] phase;
        logic [15:0] tick;
        logic       scl_low;
        logic       sda_low;
        logic [7:0] rdata;
        logic       rack;
        logic       done;
    } ctl_t;

    ctl_t c_reg;
    ctl_t c_next;
    logic step;

    assign step = (c_reg.tick == 16'(HALF_CYCLES - 1));

    // ==========================================================
    // Bit sequencer: each bit is two low half-steps then one high half-step of SCL
    always_comb
    begin
        c_next          = c_reg;
        c_next.sda_sync = {c_reg.sda_sync[0], link.sda};
        c_next.done     = 1'b0;
        c_next.tick     = step ? '0 : c_reg.tick + 16'h1;
        unique case (c_reg.state)
            C_IDLE:
            begin
                c_next.tick = '0;
                if (cmd_valid)
                begin
                    c_next.op      = cmd_op;
                    c_next.phase   = '0;
                    c_next.bit_cnt = '0;
                    // Byte plus its acknowledge slot; for reads our ack goes last
                    c_next.shift   = (cmd_op == 3'h3) ? {8'hff, ~cmd_ack} : {cmd_data, 1'b1};
                    c_next.state   = (cmd_op[2:1] == 2'h1) ? C_BITS : (cmd_op == 3'h4 ? C_RECV : C_COND);
                end
            end
            C_COND:
                if (step)
                begin
                    c_next.phase = c_reg.phase + 2'h1;
                    // SCL is pulled low before SDA moves, so no false condition appears
                    unique case (c_reg.phase)
                        2'h0:
                            c_next.scl_low = 1'b1;
                        2'h1:
                            c_next.sda_low = (c_reg.op == 3'h1);
                        2'h2:
                            c_next.scl_low = 1'b0;
                        default:
                        begin
                            c_next.sda_low = (c_reg.op == 3'h0);
                            c_next.state   = C_DONE;
                        end
                    endcase
                end
            C_BITS, C_RECV:
                if (step)
                begin
                    if (c_reg.phase == 2'h0)
                    begin
                        // The closing falling edge lets the target finish its ack or byte
                        c_next.scl_low = 1'b1;
                        c_next.phase   = 2'h1;
                        if ((c_reg.state == C_BITS && c_reg.bit_cnt == 4'(rtc_link_pkg::BYTE_BITS + 1))
                            || (c_reg.state == C_RECV && c_reg.bit_cnt == 4'(rtc_link_pkg::RECOVERY_CLOCKS)))
                            c_next.state = C_DONE;
                    end
                    else if (c_reg.phase == 2'h1)
                    begin
                        // Data set while SCL low; this end samples it from the synchroniser as SCL is released
                        c_next.sda_low = (c_reg.state == C_BITS) & ~c_reg.shift[8];
                        c_next.phase   = 2'h2;
                    end
                    else
                    begin
                        c_next.scl_low = 1'b0;
                        c_next.phase   = 2'h0;
                        c_next.shift   = {c_reg.shift[7:0], 1'b1};
                        // Data bits fill the byte; the ninth bit is the acknowledge only
                        if (c_reg.bit_cnt < 4'(rtc_link_pkg::BYTE_BITS))
                            c_next.rdata = {c_reg.rdata[6:0], c_reg.sda_sync[1]};
                        else
                            c_next.rack  = ~c_reg.sda_sync[1];
                        c_next.bit_cnt = c_reg.bit_cnt + 4'h1;
                    end
                end
            C_DONE:
            begin
                c_next.done  = 1'b1;
                c_next.state = C_IDLE;
            end
            default:
                c_next.state = C_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            c_reg          <= '0;
            c_reg.state    <= C_IDLE;
            c_reg.sda_sync <= 2'h3;
        end
        else
            c_reg <= c_next;
    end

    assign link.scl_out     = 1'b0;
    assign link.scl_oe      = c_reg.scl_low;
    assign link.sda_ctl_out = 1'b0;
    assign link.sda_ctl_oe  = c_reg.sda_low;
    assign cmd_ready        = (c_reg.state == C_IDLE);
    assign rsp_valid        = c_reg.done;
    assign rsp_data         = c_reg.rdata;
    assign rsp_ack          = c_reg.rack;
endmodule // rtc_i2c_controller

// File: logic/rtc_i2c_target.sv
/*
 * Target end of the link: address match, direction, register pointer and byte moves.
 * Assumes the register space lives outside and answers reads combinationally.
 */
`timescale 1ns/1ps
// What this block and its controller do
// - Every byte is followed by one acknowledge clock
// - No limit on bytes per transaction
// - Acknowledge every byte received when addressed
// - Controller acknowledges read bytes except last
// - Acknowledger holds SDA low through clock high
// - Controller ends read with not-acknowledge
// - After read not-acknowledge, release SDA high
// - Answer only to address 1010001
// - Controller sends address after each START
// - Address bit 0 selects write or read
// - STOP or new START ends a write
// - Register address is a 5-bit field
// - Upper three register address bits ignored
// - Controller recovers stuck bus with nine clocks
// - Nine recovery clocks return a target that is sending data to idle
// - Controller offers a software recovery trigger
// - START is SDA fall with SCL high
// - STOP is SDA rise with SCL high
// - SDA changes only while SCL is low
module rtc_i2c_target
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    rtc_link_if.target       link,
    output logic [4:0]       reg_addr,
    output logic [7:0]       wr_data,
    output logic             wr_strobe,
    input  wire logic [7:0]  rd_data,
    output logic             rd_strobe,
    output logic             busy
);
    typedef enum logic [4:0]
    {
        ST_IDLE  = 5'h01,
        ST_RECV  = 5'h02,
        ST_RACK  = 5'h04,
        ST_SEND  = 5'h08,
        ST_SACK  = 5'h10
    } state_t;

    typedef struct packed
    {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic       scl_prev;
        logic       sda_prev;
        state_t     state;
        logic [7:0] shift;
        logic [3:0] bit_cnt;
        logic       addr_phase;
        logic       ptr_phase;
        logic       reading;
        logic       ack_drive;
        logic       nacked;
        logic       sda_low;
        logic [4:0] ptr;
        logic [7:0] wdata;
        logic       wr_pulse;
        logic       rd_pulse;
    } tgt_t;

    tgt_t s_reg;
    tgt_t s_next;

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // Second flop stage only is looked at
    assign scl_s      = s_reg.scl_sync[1];
    assign sda_s      = s_reg.sda_sync[1];
    assign scl_rise   = scl_s & ~s_reg.scl_prev;
    assign scl_fall   = ~scl_s & s_reg.scl_prev;
    assign start_seen = scl_s & s_reg.scl_prev & s_reg.sda_prev & ~sda_s;
    assign stop_seen  = scl_s & s_reg.scl_prev & ~s_reg.sda_prev & sda_s;

    // ==========================================================
    // Protocol engine
    always_comb
    begin
        s_next          = s_reg;
        s_next.scl_sync = {s_reg.scl_sync[0], link.scl};
        s_next.sda_sync = {s_reg.sda_sync[0], link.sda};
        s_next.scl_prev = scl_s;
        s_next.sda_prev = sda_s;
        s_next.wr_pulse = 1'b0;
        s_next.rd_pulse = 1'b0;
        if (start_seen)
        begin
            // Any state: restart address reception, ends a write too
            s_next.state      = ST_RECV;
            s_next.bit_cnt    = '0;
            s_next.addr_phase = 1'b1;
            s_next.sda_low    = 1'b0;
        end
        else if (stop_seen)
        begin
            s_next.state   = ST_IDLE;
            s_next.sda_low = 1'b0;
        end
        else
        begin
            unique case (s_reg.state)
                ST_IDLE:
                    s_next.sda_low = 1'b0;
                ST_RECV:
                    if (scl_rise)
                    begin
                        s_next.shift   = {s_reg.shift[6:0], sda_s};
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && s_reg.bit_cnt == 4'(rtc_link_pkg::BYTE_BITS))
                    begin
                        s_next.bit_cnt = '0;
                        s_next.state   = ST_RACK;
                        if (s_reg.addr_phase)
                        begin
                            // Only our address earns an acknowledge
                            if (s_reg.shift[7:1] == rtc_link_pkg::TARGET_ADDR)
                            begin
                                s_next.sda_low   = 1'b1;
                                s_next.reading   = (s_reg.shift[0] == rtc_link_pkg::DIR_READ);
                                s_next.ptr_phase = (s_reg.shift[0] == rtc_link_pkg::DIR_WRITE);
                            end
                            else
                                s_next.state = ST_IDLE;
                            s_next.addr_phase = 1'b0;
                        end
                        else if (s_reg.ptr_phase)
                        begin
                            s_next.ptr       = s_reg.shift[4:0];
                            s_next.ptr_phase = 1'b0;
                            s_next.sda_low   = 1'b1;
                        end
                        else
                        begin
                            s_next.wdata    = s_reg.shift;
                            s_next.wr_pulse = 1'b1;
                            s_next.sda_low  = 1'b1;
                        end
                    end
                ST_RACK:
                    // Hold low across the whole high phase, drop on falling edge
                    if (scl_fall)
                    begin
                        s_next.sda_low = 1'b0;
                        if (s_reg.reading)
                        begin
                            s_next.state   = ST_SEND;
                            s_next.shift   = rd_data;
                            s_next.sda_low = ~rd_data[7];
                            s_next.bit_cnt = 4'h1;
                        end
                        else
                            s_next.state = ST_RECV;
                    end
                ST_SEND:
                    if (scl_fall)
                    begin
                        if (s_reg.bit_cnt == 4'(rtc_link_pkg::BYTE_BITS))
                        begin
                            s_next.sda_low  = 1'b0;                          // release for master ack
                            s_next.state    = ST_SACK;
                            s_next.ptr      = s_reg.ptr + 5'h01;
                            s_next.rd_pulse = 1'b1;
                        end
                        else
                        begin
                            s_next.sda_low = ~s_reg.shift[3'(7 - s_reg.bit_cnt)];
                            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                        end
                    end
                ST_SACK:
                    if (scl_rise)
                        s_next.nacked = sda_s;
                    else if (scl_fall)
                    begin
                        if (s_reg.nacked)
                            s_next.state = ST_IDLE;
                        else
                        begin
                            s_next.state   = ST_SEND;
                            s_next.shift   = rd_data;
                            s_next.sda_low = ~rd_data[7];
                            s_next.bit_cnt = 4'h1;
                        end
                    end
                default:
                    s_next.state = ST_IDLE;
            endcase
        end
        // Write data moves the pointer after the strobe has used it
        if (s_reg.wr_pulse)
            s_next.ptr = s_reg.ptr + 5'h01;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_reg       <= '0;
            s_reg.state <= ST_IDLE;
            s_reg.scl_sync <= 2'h3;
            s_reg.sda_sync <= 2'h3;
            s_reg.scl_prev <= 1'b1;
            s_reg.sda_prev <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    // ==========================================================
    // Outputs: open-drain, enable only when pulling low
    assign link.sda_tgt_out = 1'b0;
    assign link.sda_tgt_oe  = s_reg.sda_low;
    assign reg_addr         = s_reg.ptr;
    assign wr_data          = s_reg.wdata;
    assign wr_strobe        = s_reg.wr_pulse;
    assign rd_strobe        = s_reg.rd_pulse;
    assign busy             = (s_reg.state != ST_IDLE);
endmodule // rtc_i2c_target

// File: logic/rtc_link_if.sv
/*
 * Open-drain two-wire link joining controller and target.
 * Assumes pull-ups: a line reads low only while some end enables its driver.
 */
`timescale 1ns/1ps
interface rtc_link_if;
    logic scl_out;
    logic scl_oe;
    logic sda_ctl_out;
    logic sda_ctl_oe;
    logic sda_tgt_out;
    logic sda_tgt_oe;
    logic scl;
    logic sda;

    // Wired-and of the drivers with the pull-up; SCL has the controller's only, SDA both ends'
    assign scl = ~(scl_oe & ~scl_out);
    assign sda = ~((sda_ctl_oe & ~sda_ctl_out) | (sda_tgt_oe & ~sda_tgt_out));

    modport controller (output scl_out, output scl_oe, output sda_ctl_out, output sda_ctl_oe,
                        input scl, input sda);
    modport target     (output sda_tgt_out, output sda_tgt_oe, input scl, input sda);
endinterface

// File: logic/rtc_link_pkg.sv
/*
 * Shared constants for the two-wire serial link between the clock target and its controller.
 * Assumes both ends run on one 125 MHz system clock and share this package.
 */
package rtc_link_pkg;
    // ==========================================================
    // Framing
    localparam int unsigned BYTE_BITS       = 8;
    localparam logic [6:0]  TARGET_ADDR     = 7'h51;    // 1010001
    localparam logic        DIR_WRITE       = 1'b0;
    localparam logic        DIR_READ        = 1'b1;
    localparam int unsigned REG_ADDR_BITS   = 5;
    localparam int unsigned RECOVERY_CLOCKS = 9;
    // ==========================================================
    // Timing
    localparam int unsigned CLOCK_MHZ       = 125;
    localparam int unsigned SCL_HALF_NS     = 1250;     // about 265 kHz bus: three half steps of 157 cycles per bit
    localparam int unsigned SCL_HALF_CYCLES = (SCL_HALF_NS * CLOCK_MHZ + 999) / 1000;
endpackage

// File: sim/rtc_link_assertions.sv
/*
 * Checker for the shared two-wire link between controller and clock target.
 * Assumes SCL and SDA change only on the system clock and the bench instantiates it beside the link.
 */
`timescale 1ns/1ps
module rtc_link_assertions
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_tgt_oe,
    input wire logic busy
);
    // ==========================================================
    // Bus decode
    logic       scl_q;
    logic       sda_q;
    logic       first;
    logic       addressed;
    logic       dir;
    logic       nack_hold;
    logic [3:0] cnt;
    logic [7:0] sh;
    wire logic  rise = scl & ~scl_q;
    wire logic  start = scl & scl_q & sda_q & ~sda;
    wire logic  stop = scl & scl_q & ~sda_q & sda;
    wire logic  ack_rise = rise & (cnt == 4'd8);

    // Bit counter and byte shifter; lines start released so no false START at reset
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            first     <= 1'b1;
            addressed <= 1'b0;
            dir       <= 1'b0;
            nack_hold <= 1'b0;
            cnt       <= 4'd0;
            sh        <= 8'h00;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            if (start || stop)
            begin
                cnt       <= 4'd0;
                first     <= start;
                nack_hold <= 1'b0;
            end
            else if (rise)
            begin
                sh  <= {sh[6:0], sda};
                cnt <= (cnt == 4'd9) ? 4'd1 : cnt + 4'd1;
                if (cnt == 4'd8)
                begin
                    first <= 1'b0;
                    if (first)
                    begin
                        addressed <= (sh[7:1] == rtc_link_pkg::TARGET_ADDR);
                        dir       <= sh[0];
                    end
                    else if (addressed && dir && sda)
                        nack_hold <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_tgt_hold_high: assert property ((scl && $past(scl)) |-> $stable(sda_tgt_oe))
        else $error("target drive moved while clock high");
    a_tgt_launch_low: assert property ($rose(sda_tgt_oe) |-> !scl && !$past(scl))
        else $error("target drive launched near clock high");
    a_start_busy: assert property (start |-> ##[1:8] busy)
        else $error("start not seen by target");
    a_stop_idle: assert property (stop |-> ##[1:8] !busy)
        else $error("target not idle after stop");
    a_addr_ack: assert property ((ack_rise && first) |-> sda == (sh[7:1] != rtc_link_pkg::TARGET_ADDR))
        else $error("address acknowledge wrong");
    a_write_ack: assert property ((ack_rise && !first && addressed && !dir) |-> !sda)
        else $error("written byte not acknowledged");
    a_nack_release: assert property (nack_hold |-> !sda_tgt_oe)
        else $error("target drives after read end");
    a_unaddr_quiet: assert property ((!first && !addressed) |-> !sda_tgt_oe)
        else $error("target drives when not addressed");
endmodule // rtc_link_assertions

// File: sim/tb_top.sv
/*
 * Bench joining controller and target over one link, with a register space model on the target side.
 * Assumes the controller command handshake and op codes of the design hand-over.
 */
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb_top;
    localparam logic [2:0] OP_START = 3'h0;
    localparam logic [2:0] OP_STOP  = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_READ  = 3'h3;
    localparam logic [2:0] OP_RECOV = 3'h4;
    localparam logic [7:0] ADDR_WR  = {rtc_link_pkg::TARGET_ADDR, rtc_link_pkg::DIR_WRITE};
    localparam logic [7:0] ADDR_RD  = {rtc_link_pkg::TARGET_ADDR, rtc_link_pkg::DIR_READ};

    logic       clock = 1'b0;
    logic       reset_n = 1'b0;
    logic       cmd_valid;
    logic [2:0] cmd_op;
    logic [7:0] cmd_data;
    logic       cmd_ack;
    logic       cmd_ready;
    logic [7:0] rsp_data;
    logic       rsp_ack;
    logic       rsp_valid;
    logic [4:0] reg_addr;
    logic [7:0] wr_data;
    logic       wr_strobe;
    logic [7:0] rd_data;
    logic       busy;
    logic       rd_strobe;
    int         rd_count = 0;
    logic [7:0] mem [32];
    logic [7:0] exp_mem [32];
    int         fail_count = 0;
    int         total_checks = 0;
    integer     seed = 32'ha079;

    rtc_link_if link();

    // ==========================================================
    // Clock and register space; reads answer at once, writes land on the strobe
    always #4 clock = ~clock;
    assign rd_data = mem[reg_addr];
    always @(posedge clock)
        if (wr_strobe === 1'b1)
            mem[reg_addr] <= wr_data;
    // Count read byte pulses, one per byte sent
    always @(posedge clock)
        if (rd_strobe === 1'b1)
            rd_count <= rd_count + 1;

    rtc_i2c_target u_rtc_i2c_target (.clock(clock), .reset_n(reset_n), .link(link), .reg_addr(reg_addr),
        .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_data(rd_data), .rd_strobe(rd_strobe), .busy(busy));
    rtc_i2c_controller #(.HALF_CYCLES(6)) u_rtc_i2c_controller (.clock(clock), .reset_n(reset_n),
        .link(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
        .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_valid(rsp_valid));
    rtc_link_assertions u_rtc_link_assertions (.clock(clock), .reset_n(reset_n), .scl(link.scl),
        .sda(link.sda), .sda_tgt_oe(link.sda_tgt_oe), .busy(busy));

    // ==========================================================
    // Tasks
    task automatic finish_test;
        $display("checks=%0d errors=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One command, held until taken, then wait for its answer pulse
    task automatic op(input logic [2:0] code, input logic [7:0] data, input logic ack_in);
        int n;
        n = 0;
        cmd_op <= code;
        cmd_data <= data;
        cmd_ack <= ack_in;
        cmd_valid <= 1'b1;
        @(posedge clock);
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        cmd_valid <= 1'b0;
        n = 0;
        @(posedge clock);
        while (rsp_valid !== 1'b1 && n < 4000)
        begin
            @(posedge clock);
            n++;
        end
        if (n >= 4000)
            fail_count++;
    endtask

    // Only the low five pointer bits select a register, so random upper bits must not matter
    task automatic wr_xfer(input logic [7:0] ptr, input int n);
        logic [7:0] d;
        logic [4:0] a;
        a = ptr[4:0];
        op(OP_START, 8'h00, 1'b1);
        op(OP_WRITE, ADDR_WR, 1'b1);
        `CHECK(rsp_ack, 1'b1);
        op(OP_WRITE, ptr, 1'b1);
        `CHECK(rsp_ack, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            d = $random(seed);
            exp_mem[a] = d;
            a++;
            op(OP_WRITE, d, 1'b1);
            `CHECK(rsp_ack, 1'b1);
        end
        op(OP_STOP, 8'h00, 1'b1);
        `CHECK({link.scl, link.sda}, 2'b11);
    endtask

    // Pointer set by a write, then a repeated start turns the bus round for reading
    task automatic rd_xfer(input logic [7:0] ptr, input int n);
        logic [4:0] a;
        int         c0;
        a = ptr[4:0];
        c0 = rd_count;
        op(OP_START, 8'h00, 1'b1);
        op(OP_WRITE, ADDR_WR, 1'b1);
        op(OP_WRITE, ptr, 1'b1);
        op(OP_START, 8'h00, 1'b1);
        op(OP_WRITE, ADDR_RD, 1'b1);
        `CHECK(rsp_ack, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            op(OP_READ, 8'h00, logic'(i != n - 1));
            `CHECK(rsp_data, exp_mem[a]);
            a++;
        end
        op(OP_STOP, 8'h00, 1'b1);
        `CHECK({link.scl, link.sda}, 2'b11);
        `CHECK(rd_count - c0, n);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        logic [7:0] p;
        int         n;
        logic [6:0] bad [4];
        bad = '{7'h50, 7'h53, 7'h11, 7'h71};
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_data = 8'h00;
        cmd_ack = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            exp_mem[i] = $random(seed);
            mem[i] = exp_mem[i];
        end
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        `CHECK({cmd_ready, busy, link.scl, link.sda}, 4'b1011);
        for (int k = 0; k < 6; k++)
        begin
            p = $random(seed);
            n = 1 + $unsigned($random(seed)) % 4;
            wr_xfer(p, n);
            rd_xfer(p, n);
        end
        // Long bursts across the pointer wrap
        wr_xfer(8'hfe, 36);
        rd_xfer(8'h3e, 36);
        // Near-miss addresses in both directions stay unanswered
        for (int j = 0; j < 4; j++)
        begin
            op(OP_START, 8'h00, 1'b1);
            op(OP_WRITE, {bad[j], j[0]}, 1'b1);
            `CHECK({rsp_ack, busy}, 2'b00);
            op(OP_STOP, 8'h00, 1'b1);
        end
        // Nine blind clocks while the target is about to send data
        op(OP_START, 8'h00, 1'b1);
        op(OP_WRITE, ADDR_RD, 1'b1);
        `CHECK(rsp_ack, 1'b1);
        op(OP_RECOV, 8'h00, 1'b1);
        // The target sees the last falling edge only after its synchroniser
        repeat (8) @(posedge clock);
        `CHECK({busy, link.sda}, 2'b01);
        op(OP_STOP, 8'h00, 1'b1);
        rd_xfer(8'h05, 2);
        finish_test;
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (80000) @(posedge clock);
        fail_count++;
        finish_test;
    end
endmodule // tb_top
